/* comparator_cfg.svh */
`ifndef COMPARATOR_CFG_SVH
`define COMPARATOR_CFG_SVH
`define MODE_SEL_OFS 8'h9D
`define INPUT_SEL_OFS 8'h9F
`define STATUS_OFS 8'hA0
`define MODE_SEL_RST 8'h02
`define INPUT_SEL_RST 8'h77
`define MODE_SEL_WMASK 8'h33
`define RISE_IE_BIT 5
`define FALL_IE_BIT 4
`define STAT_OUT_BIT 2
`define STAT_RISE_BIT 1
`define STAT_FALL_BIT 0
`define SMALL_CODE_MAX 4'h2
`endif

/* comparator_input_mode_regs.sv */
// Implementation choice: the Wishbone register port.
`timescale 1ns/100ps
`include "comparator_cfg.svh"
// Functional notes
// [R1] upper nibble selects negative input pin
// [R2] lower nibble selects positive input pin
// [R3] codes above two exist only on large parts
// [R4] mode bit 7 reserved, reads zero
// [R5] mode bits 6,3,2 unused, read zero
// [R6] mode bit 5 enables rising-edge interrupt
// [R7] mode bit 4 enables falling-edge interrupt
// [R8] irq needs local and global enable
// [R9] mode bits 1:0 pick response time
// [R10] sticky rise and fall edge flags
// [R11] result bit shows positive above negative
// [R12] irq is flag-and-enable ORed
module comparator_input_mode_regs (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [7:0] wb_dat_i,
	input wire logic wb_sel_i,
	output logic [7:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic compareRaw,
	input wire logic comparator_global_irq_enable,
	input wire logic largeVariant,
	output logic [3:0] negative_input_code,
	output logic [3:0] positive_input_code,
	output logic negInputValid,
	output logic posInputValid,
	output logic [1:0] response_time_mode,
	output logic compare_result_bit,
	output logic comparatorIrq
);
	typedef struct packed {
		comparator_pkg::bus_state_t bus;
		logic ack;
		logic [7:0] rdata;
		logic [7:0] inputSel;
		logic riseIe;
		logic fallIe;
		comparator_pkg::response_mode_t mode;
		logic riseFlag;
		logic fallFlag;
		logic result;
		logic negValid;
		logic posValid;
		logic irq;
		logic globalMeta;
		logic globalSync;
		logic largeMeta;
		logic largeSync;
	} regs_state_t;
	regs_state_t state_ff;
	regs_state_t nxt_state;
	logic compareSync;
	logic risePulse;
	logic fallPulse;
	logic access;
	logic wrEn;
	logic [7:0] modeRead;
	logic [7:0] statusRead;
	edge_catch edge_catch_i (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.compareRaw(compareRaw),
		.compareSync(compareSync),
		.risePulse(risePulse),
		.fallPulse(fallPulse)
	);
	always_comb begin
		nxt_state = state_ff;
		// ack kept in its own flop so the output is not a state decode
		nxt_state.ack = 1'b0;
		access = wb_cyc_i & wb_stb_i;
		wrEn = 1'b0;
		modeRead = 8'h00;
		// reserved and unused bits come back as zero
		modeRead[`RISE_IE_BIT] = state_ff.riseIe; // [R4] [R5]
		modeRead[`FALL_IE_BIT] = state_ff.fallIe;
		modeRead[1:0] = state_ff.mode;
		statusRead = 8'h00;
		statusRead[`STAT_OUT_BIT] = state_ff.result;
		statusRead[`STAT_RISE_BIT] = state_ff.riseFlag;
		statusRead[`STAT_FALL_BIT] = state_ff.fallFlag;
		nxt_state.globalMeta = comparator_global_irq_enable;
		nxt_state.globalSync = state_ff.globalMeta;
		nxt_state.largeMeta = largeVariant;
		nxt_state.largeSync = state_ff.largeMeta;
		case (state_ff.bus)
			comparator_pkg::BUS_IDLE: begin
				if (access) begin
					nxt_state.bus = comparator_pkg::BUS_ACK;
					nxt_state.ack = 1'b1;
					wrEn = wb_we_i & wb_sel_i;
					case (wb_adr_i)
						`MODE_SEL_OFS: nxt_state.rdata = modeRead;
						`INPUT_SEL_OFS: nxt_state.rdata = state_ff.inputSel;
						`STATUS_OFS: nxt_state.rdata = statusRead;
						default: nxt_state.rdata = 8'h00;
					endcase
				end
			end
			comparator_pkg::BUS_ACK: begin
				nxt_state.bus = comparator_pkg::BUS_DONE;
			end
			comparator_pkg::BUS_DONE: begin
				if (!access) begin
					nxt_state.bus = comparator_pkg::BUS_IDLE;
				end
			end
			default: nxt_state.bus = comparator_pkg::BUS_IDLE;
		endcase
		if (wrEn && wb_adr_i == `MODE_SEL_OFS) begin
			nxt_state.riseIe = wb_dat_i[`RISE_IE_BIT]; // [R6]
			nxt_state.fallIe = wb_dat_i[`FALL_IE_BIT]; // [R7]
			nxt_state.mode = comparator_pkg::response_mode_t'(wb_dat_i[1:0]); // [R9]
		end
		if (wrEn && wb_adr_i == `INPUT_SEL_OFS) begin
			nxt_state.inputSel = wb_dat_i; // [R1] [R2]
		end
		// write one to clear; a new edge in the same cycle wins
		if (wrEn && wb_adr_i == `STATUS_OFS) begin
			if (wb_dat_i[`STAT_RISE_BIT]) begin
				nxt_state.riseFlag = 1'b0;
			end
			if (wb_dat_i[`STAT_FALL_BIT]) begin
				nxt_state.fallFlag = 1'b0;
			end
		end
		if (risePulse) begin
			nxt_state.riseFlag = 1'b1; // [R10]
		end
		if (fallPulse) begin
			nxt_state.fallFlag = 1'b1; // [R10]
		end
		nxt_state.result = compareSync; // [R11]
		// small parts only have pins for codes 0..2
		nxt_state.negValid = state_ff.largeSync |
			(nxt_state.inputSel[7:4] <= `SMALL_CODE_MAX); // [R3]
		nxt_state.posValid = state_ff.largeSync |
			(nxt_state.inputSel[3:0] <= `SMALL_CODE_MAX); // [R3]
		nxt_state.irq = state_ff.globalSync &
			((nxt_state.riseFlag & nxt_state.riseIe) |
			(nxt_state.fallFlag & nxt_state.fallIe)); // [R8] [R12]
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= '0;
			state_ff.bus <= comparator_pkg::BUS_IDLE;
			state_ff.inputSel <= `INPUT_SEL_RST;
			state_ff.mode <= comparator_pkg::response_mode_t'(2'(`MODE_SEL_RST));
		end else begin
			state_ff <= nxt_state;
		end
	end
	assign wb_dat_o = state_ff.rdata;
	assign wb_ack_o = state_ff.ack;
	assign negative_input_code = state_ff.inputSel[7:4];
	assign positive_input_code = state_ff.inputSel[3:0];
	assign negInputValid = state_ff.negValid;
	assign posInputValid = state_ff.posValid;
	assign response_time_mode = state_ff.mode;
	assign compare_result_bit = state_ff.result;
	assign comparatorIrq = state_ff.irq;
endmodule // comparator_input_mode_regs

/* comparator_input_mode_regs_props.sv */
`timescale 1ns/100ps
`include "comparator_cfg.svh"
module comparator_input_mode_regs_props (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic wb_sel_i,
	input wire logic wb_ack_o,
	input wire logic [7:0] wb_adr_i,
	input wire logic [7:0] wb_dat_i,
	input wire logic [7:0] wb_dat_o,
	input wire logic compareRaw,
	input wire logic comparator_global_irq_enable,
	input wire logic largeVariant,
	input wire logic [3:0] negative_input_code,
	input wire logic [3:0] positive_input_code,
	input wire logic negInputValid,
	input wire logic posInputValid,
	input wire logic compare_result_bit,
	input wire logic comparatorIrq,
	input wire logic [1:0] response_time_mode
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	wire logic wrAck = wb_ack_o && wb_we_i && wb_sel_i;
	wire logic g = comparator_global_irq_enable;
	sequence s_take; wb_cyc_i && $rose(wb_stb_i); endsequence
	sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence
	property p_ack; s_take |=> s_ans; endproperty
	a_ack: assert property (p_ack) else $error("ack not one cycle after request");
	property p_sel; wrAck && wb_adr_i == `INPUT_SEL_OFS |->
		{negative_input_code, positive_input_code} == wb_dat_i; endproperty
	a_sel: assert property (p_sel) else $error("input codes not written");
	property p_rsv; wb_ack_o && !wb_we_i && wb_adr_i == `MODE_SEL_OFS |->
		(wb_dat_o & 8'hCC) == 8'h00; endproperty
	a_rsv: assert property (p_rsv) else $error("unused mode bits read set");
	property p_rtm; wrAck && wb_adr_i == `MODE_SEL_OFS |->
		response_time_mode == wb_dat_i[1:0]; endproperty
	a_rtm: assert property (p_rtm) else $error("response mode not written");
	// sync chain lag is three cycles, four leaves margin
	property p_vld; !largeVariant && $past(largeVariant, 4) == 1'b0
		&& $stable(negative_input_code) && $stable(positive_input_code) |->
		negInputValid == (negative_input_code <= `SMALL_CODE_MAX)
		&& posInputValid == (positive_input_code <= `SMALL_CODE_MAX); endproperty
	a_vld: assert property (p_vld) else $error("code valid wrong on small part");
	property p_res; $stable(compareRaw) [*5] |-> compare_result_bit == compareRaw; endproperty
	a_res: assert property (p_res) else $error("result bit not tracking");
	property p_gate; comparatorIrq |-> $past(g, 2) || $past(g, 3) || $past(g, 4); endproperty
	a_gate: assert property (p_gate) else $error("irq without global enable");
	// a write drops irq at its take edge, so the fall is seen with ack
	property p_keep; $fell(comparatorIrq) |-> wrAck
		|| !($past(g, 2) && $past(g, 3) && $past(g, 4)); endproperty
	a_keep: assert property (p_keep) else $error("irq dropped on its own");
endmodule // comparator_input_mode_regs_props
bind comparator_input_mode_regs comparator_input_mode_regs_props comparator_input_mode_regs_props_i (
	.ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_sel_i, .wb_ack_o, .wb_adr_i,
	.wb_dat_i, .wb_dat_o, .compareRaw, .comparator_global_irq_enable, .largeVariant,
	.negative_input_code, .positive_input_code, .negInputValid, .posInputValid,
	.compare_result_bit, .comparatorIrq, .response_time_mode);

/* comparator_input_mode_regs_tb_top.sv */
`timescale 1ns/100ps
module comparator_input_mode_regs_tb_top;
	logic ref_clk = 0, rst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_sel_i = 0;
	logic compareRaw = 0, comparator_global_irq_enable = 0, largeVariant = 0;
	logic selOn = 1;
	logic [7:0] wb_adr_i = 8'h00, wb_dat_i = 8'h00, wb_dat_o, q;
	logic wb_ack_o, negInputValid, posInputValid, compare_result_bit, comparatorIrq;
	logic [3:0] negative_input_code, positive_input_code;
	logic [1:0] response_time_mode;
	int fails = 0, compares = 0;
	comparator_input_mode_regs comparator_input_mode_regs_i (.ref_clk, .rst_n, .wb_cyc_i,
		.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .compareRaw,
		.comparator_global_irq_enable, .largeVariant, .negative_input_code, .positive_input_code,
		.negInputValid, .posInputValid, .response_time_mode, .compare_result_bit, .comparatorIrq);
	initial forever #25 ref_clk = ~ref_clk;
	task chk(input string n, input logic [7:0] s, e);
		compares++;
		if (s !== e) begin
			fails++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, d);
		@(posedge ref_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_sel_i <= selOn;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task rd(input string n, input logic [7:0] a, e);
		bus(1'b0, a, 8'h00);
		chk(n, q, e);
	endtask
	task tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task summarize;
		$display("fails %0d compares %0d", fails, compares);
		if (fails == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		tick(5000);
		fails++;
		summarize;
	end
	initial begin
		tick(16);
		rst_n <= 1'b1;
		rd("mode", 8'h9D, 8'h02);
		rd("isel", 8'h9F, 8'h77);
		rd("none", 8'h50, 8'h00);
		bus(1'b1, 8'h9F, 8'h23);
		chk("codes", {negative_input_code, positive_input_code}, 8'h23);
		// byte enable low and unmapped address must both be ignored
		selOn = 1'b0;
		bus(1'b1, 8'h9F, 8'h55);
		selOn = 1'b1;
		bus(1'b1, 8'h50, 8'hFF);
		rd("isel", 8'h9F, 8'h23);
		tick(2);
		chk("valid", {6'h00, negInputValid, posInputValid}, 8'h02);
		largeVariant <= 1'b1;
		tick(6);
		chk("valid", {6'h00, negInputValid, posInputValid}, 8'h03);
		// bit 7 always written as zero
		bus(1'b1, 8'h9D, 8'h7F);
		rd("mode", 8'h9D, 8'h33);
		for (int m = 0; m < 4; m++) begin
			bus(1'b1, 8'h9D, 8'h30 | m[7:0]);
			chk("rtm", {6'h00, response_time_mode}, m[7:0]);
		end
		comparator_global_irq_enable <= 1'b1;
		compareRaw <= 1'b1;
		tick(8);
		rd("stat", 8'hA0, 8'h06);
		chk("irq", {7'h00, comparatorIrq}, 8'h01);
		bus(1'b1, 8'h9D, 8'h13);
		tick(2);
		chk("irq", {7'h00, comparatorIrq}, 8'h00);
		compareRaw <= 1'b0;
		tick(8);
		rd("stat", 8'hA0, 8'h03);
		chk("irq", {7'h00, comparatorIrq}, 8'h01);
		comparator_global_irq_enable <= 1'b0;
		tick(6);
		chk("irq", {7'h00, comparatorIrq}, 8'h00);
		comparator_global_irq_enable <= 1'b1;
		bus(1'b1, 8'hA0, 8'h03);
		tick(2);
		rd("stat", 8'hA0, 8'h00);
		chk("irq", {7'h00, comparatorIrq}, 8'h00);
		summarize;
	end
endmodule // comparator_input_mode_regs_tb_top

/* comparator_pkg.sv */
package comparator_pkg;
	typedef enum logic [1:0] {
		RESP_FASTEST = 2'h0,
		RESP_MID_FAST = 2'h1,
		RESP_MID_LOW = 2'h2,
		RESP_LOW_POWER = 2'h3
	} response_mode_t;
	typedef enum logic [2:0] {
		BUS_IDLE = 3'h1,
		BUS_ACK = 3'h2,
		BUS_DONE = 3'h4
	} bus_state_t;
endpackage

/* edge_catch.sv */
`timescale 1ns/100ps
module edge_catch (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic compareRaw,
	output logic compareSync,
	output logic risePulse,
	output logic fallPulse
);
	typedef struct packed {
		logic meta;
		logic sync;
		logic prev;
		logic rise;
		logic fall;
	} edge_state_t;
	edge_state_t state_ff;
	edge_state_t nxt_state;
	always_comb begin
		nxt_state = state_ff;
		nxt_state.meta = compareRaw;
		nxt_state.sync = state_ff.meta;
		nxt_state.prev = state_ff.sync;
		nxt_state.rise = state_ff.sync & ~state_ff.prev;
		nxt_state.fall = ~state_ff.sync & state_ff.prev;
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end
	assign compareSync = state_ff.prev;
	assign risePulse = state_ff.rise;
	assign fallPulse = state_ff.fall;
endmodule // edge_catch
